// ### hdl/low_power_mode_control.sv
// low-power mode sequencer: stop, suspend, wake and reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.svh"
module low_power_mode_control #(
   parameter int unsigned MCD_TIMEOUT_CYC = `MCD_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   // register port
   input wire lpm_pkg::reg_req_t REG_REQ_IN,
   output logic [7:0] REG_RDATA_OUT,
   // core and wake inputs
   input wire logic INSTR_DONE_IN,
   input wire logic EXT_RST_N_IN,
   input wire logic INT_RST_REQ_IN,
   input wire logic USB_RESUME_IN,
   input wire logic HF_OSC_READY_IN,
   // control outputs
   output var lpm_pkg::gate_t GATES_OUT,
   output logic SYS_RST_OUT,
   output logic PC_LOAD_OUT,
   output logic [15:0] PC_ADDR_OUT,
   output logic WAKE_INT_OUT
);
   import lpm_pkg::*;

   localparam logic [7:0] PWR_RST = `PWR_RST;
   localparam logic [7:0] OSC_RST = `OSC_RST;
   localparam logic [7:0] REGU_RST = `REGU_RST;
   localparam logic [7:0] MCD_RST = `MCD_RST;
   localparam int unsigned RST_HOLD = `RST_HOLD_CYC;
   localparam logic [`RST_CNT_W-1:0] RST_LAST = RST_HOLD[`RST_CNT_W-1:0] - 1'b1;

   mode_t state_r;
   logic stop_sel_r;
   logic susp_r;
   logic hfsel_r;
   logic wakeie_r;
   logic regulator_stop_config_r;
   logic mcd_en_r;
   logic reg_off_r;
   logic [2:0] cause_r;
   logic [`RST_CNT_W-1:0] rst_cnt_r;
   logic [7:0] rdata_r;
   logic wake_int_r;
   logic pc_load_r;
   logic [15:0] pc_addr_r;
   logic ext_rst;
   logic mcd_to;
   logic rst_req;
   logic osc_done;
   logic enter_stop;
   logic enter_susp;
   logic wake_start;
   logic wake_end;
   logic seq_done;
   logic in_reset;
   logic wr_pwr;
   logic wr_osc;
   logic wr_regu;
   logic wr_mcd;

   assign ext_rst = !EXT_RST_N_IN;
   // with the regulator down, internal sources have no logic left to act on
   assign rst_req = ext_rst | ((INT_RST_REQ_IN | mcd_to) & !reg_off_r);
   assign in_reset = state_r == M_RESET;
   // the write must land at least one cycle before the instruction completes
   assign enter_stop = state_r == M_RUN && INSTR_DONE_IN && stop_sel_r && !rst_req;
   assign enter_susp = state_r == M_RUN && INSTR_DONE_IN && susp_r && !stop_sel_r && !rst_req;
   assign wake_start = state_r == M_SUSPEND && USB_RESUME_IN && !rst_req;
   assign wake_end = state_r == M_WAKE && osc_done && !rst_req;
   assign seq_done = in_reset && rst_cnt_r == RST_LAST && !rst_req;

   assign wr_pwr = REG_REQ_IN.wr && REG_REQ_IN.addr == `LPM_PWR_OFS;
   assign wr_osc = REG_REQ_IN.wr && REG_REQ_IN.addr == `LPM_OSC_OFS;
   assign wr_regu = REG_REQ_IN.wr && REG_REQ_IN.addr == `LPM_REGU_OFS;
   assign wr_mcd = REG_REQ_IN.wr && REG_REQ_IN.addr == `LPM_MCD_OFS;

   mcd_timer #(
      .TIMEOUT_CYC(MCD_TIMEOUT_CYC)
   ) u_mcd (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RESET_N_IN),
      .enable_in(mcd_en_r),
      .clk_lost_in(!GATES_OUT.cpu_clk_en),
      .timeout_out(mcd_to)
   );

   osc_restart u_osc (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RESET_N_IN),
      .start_in(wake_start),
      .abort_in(rst_req),
      .ready_in(HF_OSC_READY_IN),
      .done_out(osc_done)
   );

   // mode sequencing; power-up starts in the reset sequence
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_r <= M_RESET;
      end else if (rst_req) begin
         state_r <= M_RESET;
      end else begin
         unique case (state_r)
            M_RUN: begin
               if (enter_stop) begin
                  state_r <= M_STOP;
               end else if (enter_susp) begin
                  state_r <= M_SUSPEND;
               end
            end
            M_STOP: state_r <= M_STOP;
            M_SUSPEND: begin
               if (wake_start) begin
                  state_r <= M_WAKE;
               end
            end
            M_WAKE: begin
               if (wake_end) begin
                  state_r <= M_RUN;
               end
            end
            M_RESET: begin
               if (seq_done) begin
                  state_r <= M_RUN;
               end
            end
            default: state_r <= M_RESET;
         endcase
      end
   end

   // reset hold counter restarts while any source stays active
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rst_cnt_r <= '0;
         cause_r <= 3'h0;
      end else if (rst_req) begin
         rst_cnt_r <= '0;
         cause_r <= {INT_RST_REQ_IN & !reg_off_r, mcd_to & !reg_off_r, ext_rst};
      end else if (in_reset && rst_cnt_r != RST_LAST) begin
         rst_cnt_r <= rst_cnt_r + 1'b1;
      end
   end

   // power and regulator configuration
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         stop_sel_r <= PWR_RST[`PWR_STOP_BIT];
         regulator_stop_config_r <= REGU_RST[`REGU_REGULATOR_STOP_CONFIG_BIT];
         mcd_en_r <= MCD_RST[`MCD_EN_BIT];
         reg_off_r <= 1'b0;
      end else if (in_reset) begin
         stop_sel_r <= PWR_RST[`PWR_STOP_BIT];
         regulator_stop_config_r <= REGU_RST[`REGU_REGULATOR_STOP_CONFIG_BIT];
         mcd_en_r <= MCD_RST[`MCD_EN_BIT];
         reg_off_r <= 1'b0;
      end else begin
         if (wr_pwr) begin
            stop_sel_r <= REG_REQ_IN.wdata[`PWR_STOP_BIT];
         end
         if (wr_regu) begin
            regulator_stop_config_r <= REG_REQ_IN.wdata[`REGU_REGULATOR_STOP_CONFIG_BIT];
         end
         if (wr_mcd) begin
            mcd_en_r <= REG_REQ_IN.wdata[`MCD_EN_BIT];
         end
         if (enter_stop) begin
            reg_off_r <= regulator_stop_config_r;
         end
      end
   end

   // oscillator control; suspend clears itself once the wake completes
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         susp_r <= OSC_RST[`OSC_SUSP_BIT];
         wakeie_r <= OSC_RST[`OSC_WAKEIE_BIT];
         hfsel_r <= OSC_RST[`OSC_HFSEL_BIT];
      end else if (in_reset) begin
         susp_r <= OSC_RST[`OSC_SUSP_BIT];
         wakeie_r <= OSC_RST[`OSC_WAKEIE_BIT];
         hfsel_r <= OSC_RST[`OSC_HFSEL_BIT];
      end else begin
         if (wake_end) begin
            susp_r <= 1'b0;
         end
         if (wr_osc) begin
            susp_r <= REG_REQ_IN.wdata[`OSC_SUSP_BIT];
            wakeie_r <= REG_REQ_IN.wdata[`OSC_WAKEIE_BIT];
            hfsel_r <= REG_REQ_IN.wdata[`OSC_HFSEL_BIT];
         end
      end
   end

   // clock and supply gates decoded from the mode
   always_comb begin
      GATES_OUT.cpu_clk_en = 1'b1;
      GATES_OUT.periph_clk_en = 1'b1;
      GATES_OUT.int_osc_en = 1'b1;
      GATES_OUT.hf_osc_en = 1'b1;
      GATES_OUT.regulator_en = 1'b1;
      unique case (state_r)
         M_STOP: begin
            GATES_OUT.cpu_clk_en = 1'b0;
            GATES_OUT.periph_clk_en = 1'b0;
            GATES_OUT.int_osc_en = 1'b0;
            GATES_OUT.hf_osc_en = 1'b0;
            GATES_OUT.regulator_en = !reg_off_r;
         end
         M_SUSPEND: begin
            GATES_OUT.hf_osc_en = 1'b0;
            GATES_OUT.cpu_clk_en = !hfsel_r;
         end
         M_WAKE: begin
            GATES_OUT.cpu_clk_en = !hfsel_r;
         end
         default: begin
            GATES_OUT.cpu_clk_en = 1'b1;
         end
      endcase
   end

   assign SYS_RST_OUT = in_reset;

   // restart vector and wake interrupt; a wake never reloads the program counter
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         pc_load_r <= 1'b0;
         pc_addr_r <= `RESET_VECTOR;
         wake_int_r <= 1'b0;
      end else begin
         pc_load_r <= seq_done;
         if (seq_done) begin
            pc_addr_r <= `RESET_VECTOR;
         end
         wake_int_r <= wake_end && wakeie_r;
      end
   end

   assign PC_LOAD_OUT = pc_load_r;
   assign PC_ADDR_OUT = pc_addr_r;
   assign WAKE_INT_OUT = wake_int_r;

   // read data stand for one cycle only; unmapped offsets read zero
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= 8'h00;
         if (REG_REQ_IN.rd) begin
            case (REG_REQ_IN.addr)
               `LPM_PWR_OFS: rdata_r[`PWR_STOP_BIT] <= stop_sel_r;
               `LPM_OSC_OFS: begin
                  rdata_r[`OSC_SUSP_BIT] <= susp_r;
                  rdata_r[`OSC_WAKEIE_BIT] <= wakeie_r;
                  rdata_r[`OSC_HFSEL_BIT] <= hfsel_r;
               end
               `LPM_REGU_OFS: rdata_r[`REGU_REGULATOR_STOP_CONFIG_BIT] <= regulator_stop_config_r;
               `LPM_MCD_OFS: rdata_r[`MCD_EN_BIT] <= mcd_en_r;
               `LPM_STAT_OFS: begin
                  rdata_r[`STAT_STOP_BIT] <= state_r == M_STOP;
                  rdata_r[`STAT_SUSP_BIT] <= state_r == M_SUSPEND;
                  rdata_r[`STAT_REGOFF_BIT] <= reg_off_r;
                  rdata_r[`STAT_WAKE_BIT] <= state_r == M_WAKE;
                  rdata_r[`STAT_CAUSE_LSB +: 3] <= cause_r;
               end
               default: rdata_r <= 8'h00;
            endcase
         end
      end
   end

   assign REG_RDATA_OUT = rdata_r;

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   a_stop_entry: assert property (enter_stop |=> state_r == M_STOP)
      else $error("stop not entered after instruction");
   a_stop_gates: assert property (state_r == M_STOP |-> !GATES_OUT.cpu_clk_en &&
      !GATES_OUT.periph_clk_en && !GATES_OUT.int_osc_en)
      else $error("clock left running in stop");
   a_stop_exit: assert property ($past(state_r) == M_STOP && state_r != M_STOP |-> in_reset)
      else $error("stop left without reset");
   a_mcd_wake: assert property (state_r == M_STOP && mcd_to && !reg_off_r |=> in_reset)
      else $error("missing-clock timeout did not end stop");
   a_regulator_off: assert property (enter_stop && regulator_stop_config_r |=> !GATES_OUT.regulator_en)
      else $error("regulator kept on in configured stop");
   a_regoff_ignore: assert property (state_r == M_STOP && reg_off_r && EXT_RST_N_IN
      |=> state_r == M_STOP)
      else $error("internal reset acted with regulator off");
   a_susp_entry: assert property (enter_susp |=> state_r == M_SUSPEND && !GATES_OUT.hf_osc_en)
      else $error("suspend not entered");
   a_susp_cpu: assert property (state_r == M_SUSPEND && !hfsel_r |-> GATES_OUT.cpu_clk_en)
      else $error("cpu halted in suspend");
   a_susp_wake: assert property (wake_start |=> state_r == M_WAKE ##0 GATES_OUT.hf_osc_en)
      else $error("resume did not wake");
   a_wake_keep: assert property (state_r == M_WAKE |=> !PC_LOAD_OUT)
      else $error("program counter reloaded on wake");
   a_wake_int: assert property (wake_end && wakeie_r |=> WAKE_INT_OUT && state_r == M_RUN)
      else $error("wake interrupt missing");
   a_reset_vector: assert property (seq_done |=> PC_LOAD_OUT && PC_ADDR_OUT == `RESET_VECTOR)
      else $error("reset did not restart at zero");
   a_wake_hold: assert property (wake_start && hfsel_r |=> (!GATES_OUT.cpu_clk_en)[*2])
      else $error("cpu clocked before oscillator settled");

   c_stop_entry: cover property (enter_stop);
   c_suspend_wake: cover property (wake_end);
   c_mcd_reset: cover property (state_r == M_STOP && mcd_to);
endmodule
`default_nettype wire

// ### hdl/lpm_map.svh
// register offsets, field positions, reset values and timing counts of the low-power sequencer
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_PWR_OFS 8'h00
`define LPM_OSC_OFS 8'h04
`define LPM_REGU_OFS 8'h08
`define LPM_MCD_OFS 8'h0C
`define LPM_STAT_OFS 8'h10
`define PWR_STOP_BIT 1
`define OSC_SUSP_BIT 5
`define OSC_WAKEIE_BIT 6
`define OSC_HFSEL_BIT 7
`define REGU_REGULATOR_STOP_CONFIG_BIT 4
`define MCD_EN_BIT 0
`define STAT_STOP_BIT 0
`define STAT_SUSP_BIT 1
`define STAT_REGOFF_BIT 2
`define STAT_WAKE_BIT 3
`define STAT_CAUSE_LSB 4
`define PWR_RST 8'h00
`define OSC_RST 8'h80
`define REGU_RST 8'h00
`define MCD_RST 8'h01
`define RESET_VECTOR 16'h0000
`define CLK_PERIOD_NS 25
`define RST_HOLD_NS 250
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W 4
`define HFOSC_SETTLE_NS 1000
`define HFOSC_SETTLE_CYC ((`HFOSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 6
`define MCD_TIMEOUT_NS 500000
`define MCD_TIMEOUT_CYC (`MCD_TIMEOUT_NS / `CLK_PERIOD_NS)
`define MCD_CNT_W 16
`endif

// ### hdl/lpm_pkg.sv
// types shared by the low-power sequencer
package lpm_pkg;
   typedef enum logic [2:0] {M_RUN, M_STOP, M_SUSPEND, M_WAKE, M_RESET} mode_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic int_osc_en;
      logic hf_osc_en;
      logic regulator_en;
   } gate_t;
endpackage

// ### hdl/mcd_timer.sv
// missing-clock detector: times how long the cpu clock has been absent
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.svh"
module mcd_timer #(
   parameter int unsigned TIMEOUT_CYC = `MCD_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic enable_in,
   input wire logic clk_lost_in,
   // result
   output logic timeout_out
);
   localparam logic [`MCD_CNT_W-1:0] LAST = TIMEOUT_CYC[`MCD_CNT_W-1:0] - 1'b1;
   logic [`MCD_CNT_W-1:0] cnt_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= '0;
         timeout_out <= 1'b0;
      end else if (!enable_in || !clk_lost_in) begin
         cnt_r <= '0;
         timeout_out <= 1'b0;
      end else if (cnt_r == LAST) begin
         cnt_r <= '0;
         timeout_out <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         timeout_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### hdl/osc_restart.sv
// waits for the high-frequency oscillator to settle after a wake
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.svh"
module osc_restart (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic ready_in,
   // result
   output logic done_out
);
   localparam int unsigned SETTLE = `HFOSC_SETTLE_CYC;
   logic busy_r;
   logic [`SETTLE_CNT_W-1:0] cnt_r;

   // ready alone is not trusted: a minimum settle time is always served
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (abort_in) begin
            busy_r <= 1'b0;
         end else if (start_in) begin
            busy_r <= 1'b1;
            cnt_r <= '0;
         end else if (busy_r) begin
            if (cnt_r != SETTLE[`SETTLE_CNT_W-1:0]) begin
               cnt_r <= cnt_r + 1'b1;
            end else if (ready_in) begin
               done_out <= 1'b1;
               busy_r <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### test/test_low_power_mode_control.sv
// self-checking bench for the low-power mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_low_power_mode_control;
   import lpm_pkg::*;
   localparam int unsigned MCD_CYC = 20;
   logic clk;
   logic rst_n;
   reg_req_t req;
   logic [7:0] rdata;
   logic instr_done, ext_rst_n, int_rst, send_resume, usb_resume, hf_ready;
   logic [7:0] ready_delay;
   gate_t gates;
   logic sys_rst, pc_load, wake_int;
   logic [15:0] pc_addr;
   int n_mismatch, n_tests, n;
   logic [7:0] v;

   low_power_mode_control #(.MCD_TIMEOUT_CYC(MCD_CYC)) dut (
      .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
      .INSTR_DONE_IN(instr_done), .EXT_RST_N_IN(ext_rst_n), .INT_RST_REQ_IN(int_rst),
      .USB_RESUME_IN(usb_resume), .HF_OSC_READY_IN(hf_ready), .GATES_OUT(gates),
      .SYS_RST_OUT(sys_rst), .PC_LOAD_OUT(pc_load), .PC_ADDR_OUT(pc_addr), .WAKE_INT_OUT(wake_int));
   usb_host_model host (
      .clk_in(clk), .rst_n_in(rst_n), .send_resume_in(send_resume), .ready_delay_in(ready_delay),
      .hf_osc_en_in(gates.hf_osc_en), .usb_resume_out(usb_resume), .hf_ready_out(hf_ready));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      v = rdata;
      `CHK(v, e)
   endtask

   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 0) instr_done <= 1'b1;
      if (which == 1) int_rst <= 1'b1;
      if (which == 2) ext_rst_n <= 1'b0;
      if (which == 3) send_resume <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      int_rst <= 1'b0;
      ext_rst_n <= 1'b1;
      send_resume <= 1'b0;
      #1;
   endtask

   // bounded wait for the restart pulse at the end of a reset sequence
   task automatic wait_boot;
      n = 0;
      while (pc_load !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      `CHK(pc_load, 1'b1)
      `CHK(sys_rst, 1'b0)
      `CHK(pc_addr, 16'h0000)
   endtask

   initial begin
      rst_n = 1'b0;
      req = '0;
      instr_done = 1'b0;
      ext_rst_n = 1'b1;
      int_rst = 1'b0;
      send_resume = 1'b0;
      ready_delay = 8'd60;
      n_mismatch = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      wait_boot();
      `CHK(gates, 5'h1F)
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h04, 8'h80);
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h0C, 8'h01);
      wr_reg(8'h14, 8'hFF);
      rd_chk(8'h14, 8'h00);
      cyc(1);
      `CHK(rdata, 8'h00)
      $display("test boot done");

      // stop with the regulator on; host resume must not end it, an internal reset does
      wr_reg(8'h0C, 8'h00);
      wr_reg(8'h00, 8'h02);
      cyc(3);
      `CHK(gates, 5'h1F)
      pulse(0);
      `CHK(gates, 5'h01)
      pulse(3);
      cyc(30);
      `CHK(gates, 5'h01)
      `CHK(sys_rst, 1'b0)
      pulse(1);
      `CHK(sys_rst, 1'b1)
      `CHK(gates, 5'h1F)
      wait_boot();
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h0C, 8'h01);
      $display("test stop done");

      // stop with the missing-clock detector still enabled
      wr_reg(8'h00, 8'h02);
      pulse(0);
      `CHK(gates, 5'h01)
      n = 0;
      while (sys_rst !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      `CHK(sys_rst, 1'b1)
      `CHK(n >= MCD_CYC - 2, 1'b1)
      wait_boot();
      $display("test detector done");

      // regulator off: internal reset and detector timeout are both ignored
      wr_reg(8'h08, 8'h10);
      wr_reg(8'h00, 8'h02);
      pulse(0);
      `CHK(gates, 5'h00)
      @(posedge clk);
      int_rst <= 1'b1;
      repeat (60) @(posedge clk);
      int_rst <= 1'b0;
      #1;
      `CHK(sys_rst, 1'b0)
      `CHK(gates, 5'h00)
      pulse(2);
      `CHK(sys_rst, 1'b1)
      wait_boot();
      rd_chk(8'h08, 8'h00);
      $display("test regulator done");

      // suspend on the hf clock with wake interrupt, woken by the host
      // the detector would read the gated cpu clock as missing and reset mid-wake
      wr_reg(8'h0C, 8'h00);
      wr_reg(8'h04, 8'hE0);
      pulse(0);
      `CHK(gates.hf_osc_en, 1'b0)
      `CHK(gates.cpu_clk_en, 1'b0)
      `CHK(gates.regulator_en, 1'b1)
      rd_chk(8'h04, 8'hE0);
      rd_chk(8'h10, 8'h12);
      pulse(3);
      cyc(1);
      `CHK(gates.hf_osc_en, 1'b1)
      n = 0;
      while (wake_int !== 1'b1 && n < 200) begin
         `CHK(gates.cpu_clk_en, 1'b0)
         cyc(1);
         n++;
      end
      `CHK(wake_int, 1'b1)
      `CHK(n >= 58, 1'b1)
      `CHK(gates.cpu_clk_en, 1'b1)
      `CHK(pc_load, 1'b0)
      `CHK(sys_rst, 1'b0)
      cyc(1);
      `CHK(wake_int, 1'b0)
      rd_chk(8'h04, 8'hC0);
      $display("test suspend wake done");

      // suspend on another clock source, cpu keeps running, ended by the reset pin
      wr_reg(8'h04, 8'h20);
      pulse(0);
      `CHK(gates.hf_osc_en, 1'b0)
      `CHK(gates.cpu_clk_en, 1'b1)
      cyc(20);
      `CHK(wake_int, 1'b0)
      pulse(2);
      `CHK(sys_rst, 1'b1)
      wait_boot();
      rd_chk(8'h04, 8'h80);
      $display("test suspend reset done");

      // both select bits set: stop wins; status is read only
      wr_reg(8'h04, 8'hA0);
      wr_reg(8'h00, 8'h02);
      pulse(0);
      `CHK(gates, 5'h01)
      wr_reg(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h11);
      pulse(2);
      `CHK(sys_rst, 1'b1)
      wait_boot();
      $display("test priority done");
      close_out();
   end

   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      close_out();
   end
endmodule
`default_nettype wire

// ### test/usb_host_model.sv
// behavioural usb host issuing resume signalling, plus the hf oscillator's ready line
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // stimulus from the bench
   input wire logic send_resume_in,
   input wire logic [7:0] ready_delay_in,
   input wire logic hf_osc_en_in,
   // towards the device
   output logic usb_resume_out,
   output logic hf_ready_out
);
   logic [2:0] resume_cnt_r;
   logic [7:0] settle_r;
   // resume is held only a few cycles; real signalling is far longer but would bloat the run
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         resume_cnt_r <= 3'h0;
      end else if (send_resume_in) begin
         resume_cnt_r <= 3'h4;
      end else if (resume_cnt_r != 3'h0) begin
         resume_cnt_r <= resume_cnt_r - 3'h1;
      end
   end
   assign usb_resume_out = (resume_cnt_r != 3'h0);
   // a slow start-up delay lets the bench see whether the cpu waits for the oscillator
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         settle_r <= 8'h00;
      end else if (!hf_osc_en_in) begin
         settle_r <= 8'h00;
      end else if (settle_r != 8'hFF) begin
         settle_r <= settle_r + 8'h01;
      end
   end
   assign hf_ready_out = hf_osc_en_in && (settle_r >= ready_delay_in);
endmodule
`default_nettype wire
